// ===== rtl/vsp_slicer_params.sv
// Field status snapshot and line parameter registers of the data slicer.
// Assumes slicer status, strobes and samples arrive on core_clk_i.
module vsp_slicer_params (
	// Clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  reset_n_i,
	// Register port
	input  wire logic [3:0]            addr_i,
	input  wire logic [15:0]           wr_data_i,
	input  wire logic                  wr_en_i,
	input  wire logic                  rd_en_i,
	output logic      [15:0]           rd_data_o,
	// Slicer status
	input  wire vsp_pkg::vsp_status_a_t status_a_i,
	input  wire vsp_pkg::vsp_status_b_t status_b_i,
	input  wire logic                  field_done_a_i,
	input  wire logic                  field_done_b_i,
	input  wire logic                  hf_damping_line_i,
	input  wire logic [15:0]           slicer_b_widescreen_bits_i,
	input  wire logic [11:0]           line_period_value_i,
	// Slicer A data path
	input  wire logic                  cri_done_i,
	input  wire logic                  sample_valid_i,
	input  wire logic                  sample_bit_i,
	input  wire logic [6:0]            level_filter_i,
	// Slicer A control
	output vsp_pkg::vsp_line_cfg_t     line_cfg_o,
	output logic                       pll_freeze_o,
	output logic                       filter_tick_o,
	output logic                       majority_bit_o,
	output logic      [6:0]            slicing_level_o
);
	import vsp_pkg::*;

	vsp_field_status_t status_q;
	logic [15:0]       wide_q;
	logic [11:0]       period_q;
	logic [15:0]       pll_q;
	vsp_filt_reg_t     filt_q;
	vsp_filt_reg_t     wr_filt;
	vsp_serv_reg_t     wr_serv;
	vsp_serv_reg_t     serv_q;
	vsp_glob_reg_t     glob_q;
	logic              hf_acc_q;
	logic [15:0]       rd_data_q;
	vsp_line_cfg_t     cfg_q;
	logic [2:0]        div_cnt_q;
	logic [MAJ_WIN-1:0] win_q;
	logic [MAJ_WIN-1:0] win_d;
	logic              maj_q;
	logic [SUM_W-1:0]  sum_q;
	logic [SUM_W-1:0]  sum_d;
	logic [4:0]        avg_cnt_q;
	logic [4:0]        avg_len;
	logic [6:0]        avg_q;
	logic [6:0]        level_q;
	logic              snap;
	logic              tick;

	// Count ones among the newest 2n+1 samples
	function automatic logic [3:0] ones_in(input logic [MAJ_WIN-1:0] w,
		input logic [2:0] n);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 0; i < MAJ_WIN; i++) begin
			if (i <= 2 * int'(n) && w[i]) begin
				c = c + 4'h1;
			end
		end
		return c;
	endfunction

	// Write data with reserved bits dropped
	assign wr_filt = vsp_filt_reg_t'(wr_data_i & FILT_WMASK);
	assign wr_serv = vsp_serv_reg_t'(wr_data_i & SERV_WMASK);

	// Snapshot strobe from either video input
	assign snap = field_done_a_i | field_done_b_i;

	// Field status snapshot
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_q <= '0;
		end else if (snap) begin
			status_q.rsvd                  <= '0;
			status_q.hlock_a               <= status_a_i.hlock;
			status_q.vsync_stable_a        <= status_a_i.vsync_stable;
			status_q.field_parity_a        <= status_a_i.field_parity;
			status_q.hf_damping_field_flag <= hf_acc_q | hf_damping_line_i;
			status_q.noise                 <= status_a_i.noise;
			status_q.group_delay_seen      <= status_a_i.group_delay_seen;
			status_q.group_delay_polarity  <= status_a_i.group_delay_polarity;
			status_q.hlock_b               <= status_b_i.hlock;
			status_q.vsync_stable_b        <= status_b_i.vsync_stable;
			status_q.field_parity_b        <= status_b_i.field_parity;
		end
	end

	// Damping seen on any line since the last snapshot
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hf_acc_q <= 1'b0;
		end else if (snap) begin
			hf_acc_q <= 1'b0;
		end else if (hf_damping_line_i) begin
			hf_acc_q <= 1'b1;
		end
	end

	// Widescreen bits and line period snapshot
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wide_q   <= '0;
			period_q <= '0;
		end else if (snap) begin
			wide_q   <= slicer_b_widescreen_bits_i;
			period_q <= line_period_value_i;
		end
	end

	// Software writes, reserved bits masked off
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pll_q  <= REG_RESET;
			filt_q <= REG_RESET;
			serv_q <= REG_RESET;
			glob_q <= REG_RESET;
		end else if (wr_en_i) begin
			unique case (addr_i)
				REG_PLL:  pll_q  <= wr_data_i;
				REG_FILT: filt_q <= wr_filt;
				REG_SERV: serv_q <= wr_serv;
				REG_GLOB: glob_q <= wr_data_i & GLOB_WMASK;
				default: begin
				end
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_q <= '0;
		end else if (rd_en_i) begin
			unique case (addr_i)
				REG_WIDE:   rd_data_q <= wide_q;
				REG_STATUS: rd_data_q <= status_q;
				REG_PERIOD: rd_data_q <= {4'h0, period_q};
				REG_PLL:    rd_data_q <= pll_q;
				REG_FILT:   rd_data_q <= filt_q;
				REG_SERV:   rd_data_q <= serv_q;
				REG_GLOB:   rd_data_q <= glob_q;
				default:    rd_data_q <= '0;
			endcase
		end else begin
			rd_data_q <= '0;
		end
	end

	assign rd_data_o = rd_data_q;

	// Configuration for slicer A; slicer B has no such path
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_q <= '0;
		end else begin
			cfg_q.data_pll_increment <= pll_q;
			cfg_q.start_level        <= filt_q.data_start_level_a;
			cfg_q.use_ext_start      <= glob_q.external_start_level_select;
			cfg_q.accu_on            <= filt_q.level_accumulator_on;
			cfg_q.track_on           <= filt_q.clock_pll_track_on;
			cfg_q.lowpass_on         <= filt_q.lowpass_on;
			cfg_q.prefilter_on       <= filt_q.prefilter_on;
			cfg_q.pos_delay_comp     <= filt_q.force_positive_delay_comp |
				(glob_q.auto_delay_comp & status_a_i.group_delay_seen &
				!status_a_i.group_delay_polarity);
			cfg_q.neg_delay_comp     <= filt_q.force_negative_delay_comp |
				(glob_q.auto_delay_comp & status_a_i.group_delay_seen &
				status_a_i.group_delay_polarity);
			cfg_q.atten_comp         <= filt_q.force_attenuation_comp |
				(glob_q.auto_attenuation_comp &
				status_q.hf_damping_field_flag);
			cfg_q.noise_comp         <= filt_q.force_noise_comp |
				(glob_q.auto_noise_comp &
				(status_a_i.noise != NOISE_NONE));
			cfg_q.service            <= serv_q.service_standard_select;
			cfg_q.framing_code_select <= serv_q.framing_code_select;
		end
	end

	assign line_cfg_o = cfg_q;

	// Clock recovery freeze after run-in unless tracking
	assign pll_freeze_o = cri_done_i & !cfg_q.track_on;

	// Level filter clock divider
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_cnt_q <= '0;
		end else if (div_cnt_q >= serv_q.level_filter_divider) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 3'h1;
		end
	end

	assign tick = (div_cnt_q >= serv_q.level_filter_divider);
	assign filter_tick_o = tick;

	// Majority filter window
	assign win_d = {win_q[MAJ_WIN-2:0], sample_bit_i};

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			win_q <= '0;
			maj_q <= 1'b0;
		end else if (sample_valid_i) begin
			win_q <= win_d;
			maj_q <= ones_in(win_d, serv_q.majority_sample_count) >
				{1'b0, serv_q.majority_sample_count};
		end
	end

	assign majority_bit_o = maj_q;

	// Arithmetic averaging of the level filter
	assign avg_len = 5'(5'h2 << serv_q.level_average_count);
	assign sum_d   = sum_q + {5'h0, level_filter_i};

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sum_q     <= '0;
			avg_cnt_q <= '0;
			avg_q     <= '0;
		end else if (tick) begin
			if (avg_cnt_q >= avg_len - 5'h1) begin
				avg_q     <= 7'(sum_d >> ({1'b0, serv_q.level_average_count} + 3'h1));
				sum_q     <= '0;
				avg_cnt_q <= '0;
			end else begin
				sum_q     <= sum_d;
				avg_cnt_q <= avg_cnt_q + 5'h1;
			end
		end
	end

	// Slicing level choice
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_q <= '0;
		end else begin
			level_q <= cfg_q.accu_on ? avg_q : level_filter_i;
		end
	end

	assign slicing_level_o = level_q;

	// Checks on the block's own behaviour
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	status_snap_a: assert property (snap |=> status_q.hlock_a == $past(status_a_i.hlock) &&
		status_q.hlock_b == $past(status_b_i.hlock) &&
		status_q.noise == $past(status_a_i.noise))
		else $error("status snapshot wrong");

	wide_snap_a: assert property (snap |=> wide_q == $past(slicer_b_widescreen_bits_i))
		else $error("widescreen snapshot wrong");

	period_read_a: assert property (snap ##1 !snap ##1 (rd_en_i && addr_i == REG_PERIOD && !snap)
		|=> rd_data_o == {4'h0, $past(line_period_value_i, 3)})
		else $error("line period read wrong");

	hf_flag_a: assert property (snap && hf_damping_line_i |=> status_q.hf_damping_field_flag)
		else $error("damping flag lost");

	hf_clear_a: assert property (snap ##1 (!snap && !hf_damping_line_i) [*2] ##1
		(snap && !hf_damping_line_i) |=> !status_q.hf_damping_field_flag)
		else $error("damping flag not cleared");

	pll_write_a: assert property (wr_en_i && addr_i == REG_PLL
		|-> ##2 line_cfg_o.data_pll_increment == $past(wr_data_i, 2))
		else $error("pll increment not applied");

	rsvd_read_a: assert property (rd_en_i && addr_i == REG_FILT |=> !rd_data_o[15])
		else $error("reserved bit reads one");

	unmapped_zero_a: assert property (rd_en_i && addr_i > REG_GLOB |=> rd_data_o == '0)
		else $error("unmapped read not zero");

	freeze_a: assert property (cri_done_i
		|-> pll_freeze_o == !$past(filt_q.clock_pll_track_on))
		else $error("pll freeze does not follow tracking bit");

	noise_force_a: assert property (filt_q.force_noise_comp |=> line_cfg_o.noise_comp)
		else $error("noise compensation not forced");

	ext_start_a: assert property (!glob_q.external_start_level_select
		|=> !line_cfg_o.use_ext_start)
		else $error("external start level leaked");

	tick_gap_a: assert property (tick && serv_q.level_filter_divider != 3'h0 &&
		$stable(serv_q) |=> !tick)
		else $error("filter tick too often");

	maj_single_a: assert property (sample_valid_i && serv_q.majority_sample_count == 3'h0
		|=> majority_bit_o == $past(sample_bit_i))
		else $error("single sample majority wrong");

	accu_off_a: assert property (!line_cfg_o.accu_on
		|=> slicing_level_o == $past(level_filter_i))
		else $error("standard slicing level not used");

	svc_write_a: assert property (wr_en_i && addr_i == REG_SERV |-> ##2
		line_cfg_o.service == $past(wr_serv.service_standard_select, 2) &&
		line_cfg_o.framing_code_select == $past(wr_serv.framing_code_select, 2))
		else $error("service or framing code not applied");

	filt_write_a: assert property (wr_en_i && addr_i == REG_FILT |-> ##2
		line_cfg_o.start_level == $past(wr_filt.data_start_level_a, 2) &&
		line_cfg_o.accu_on == $past(wr_filt.level_accumulator_on, 2) &&
		line_cfg_o.track_on == $past(wr_filt.clock_pll_track_on, 2) &&
		line_cfg_o.lowpass_on == $past(wr_filt.lowpass_on, 2) &&
		line_cfg_o.prefilter_on == $past(wr_filt.prefilter_on, 2))
		else $error("line filter word not applied");

	pos_force_a: assert property (filt_q.force_positive_delay_comp
		|=> line_cfg_o.pos_delay_comp)
		else $error("positive delay compensation not forced");

	neg_force_a: assert property (filt_q.force_negative_delay_comp
		|=> line_cfg_o.neg_delay_comp)
		else $error("negative delay compensation not forced");

	atten_force_a: assert property (filt_q.force_attenuation_comp
		|=> line_cfg_o.atten_comp)
		else $error("attenuation compensation not forced");

	auto_off_a: assert property (!glob_q.auto_delay_comp &&
		!filt_q.force_positive_delay_comp && !filt_q.force_negative_delay_comp
		|=> !line_cfg_o.pos_delay_comp && !line_cfg_o.neg_delay_comp)
		else $error("delay compensation active while off");

	snap_b_a: assert property (field_done_b_i && !field_done_a_i |=>
		status_q.field_parity_b == $past(status_b_i.field_parity) &&
		status_q.vsync_stable_a == $past(status_a_i.vsync_stable))
		else $error("snapshot from slicer B input missed");

	tick_zero_a: assert property (serv_q.level_filter_divider == 3'h0 |-> filter_tick_o)
		else $error("undivided filter clock missing");

	maj_hold_a: assert property (!sample_valid_i |=> $stable(majority_bit_o))
		else $error("majority output moved without sample");

	period_snap_a: assert property (snap |=> period_q == $past(line_period_value_i))
		else $error("line period snapshot wrong");

endmodule

// ===== rtl/vsp_pkg.sv
// Constants, register layouts and carrier types of the slicer parameter block.
// Assumes one core clock and status inputs produced by slicer logic on that clock.
// Function
// - Latch final 16 slicer B widescreen bits
// - Report slicer A horizontal PLL lock
// - Report slicer A vertical sync stability
// - Report slicer A current field parity
// - Flag high frequency damping seen last field
// - Report two-bit noise code of slicer A
// - Report group delay detection and its sign
// - Report slicer B lock, vsync, field bits
// - Report 12-bit measured line period
// - Line configuration steers slicer A only
// - Data PLL uses 16-bit frequency increment
// - Programmed start level used when externally selected
// - Accumulator bit picks improved slicing level
// - Clock PLL freezes after run-in unless tracking
// - Low pass and prefilter enable bits
// - Delay compensation forced or automatic
// - Attenuation, noise compensation forced or automatic
// - Majority filter over 2n+1 samples
// - Average slicing level over 2..16 values
// - Filter clock is sampling clock over n+1
// - Three-bit service code selects line timing
// - Two-bit framing code selector
// - External select chooses internal or programmed thresholds
// - Snapshot status once per field, either input
// - Automatic delay compensation follows measurement
package vsp_pkg;

	// Register bus geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	// Register indices
	localparam logic [3:0] REG_WIDE   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_PERIOD = 4'h2;
	localparam logic [3:0] REG_PLL    = 4'h3;
	localparam logic [3:0] REG_FILT   = 4'h4;
	localparam logic [3:0] REG_SERV   = 4'h5;
	localparam logic [3:0] REG_GLOB   = 4'h6;

	// Writable bit masks, reserved bits excluded
	localparam logic [15:0] FILT_WMASK = 16'h7FFF;
	localparam logic [15:0] SERV_WMASK = 16'h7FFC;
	localparam logic [15:0] GLOB_WMASK = 16'h000F;
	localparam logic [15:0] REG_RESET  = 16'h0000;

	// Filter geometry
	localparam int unsigned MAJ_WIN  = 15;
	localparam int unsigned SUM_W    = 12;
	localparam logic [1:0]  NOISE_NONE = 2'h0;

	// Service standards
	typedef enum logic [2:0] {
		SVC_TELETEXT = 3'h0,
		SVC_VPS      = 3'h1,
		SVC_WSS      = 3'h2,
		SVC_CAPTION  = 3'h3,
		SVC_GUIDE    = 3'h4,
		SVC_SPARE    = 3'h5,
		SVC_RESERVED = 3'h6,
		SVC_US_WSS   = 3'h7
	} vsp_service_t;

	// Live status of slicer A
	typedef struct packed {
		logic       hlock;
		logic       vsync_stable;
		logic       field_parity;
		logic [1:0] noise;
		logic       group_delay_seen;
		logic       group_delay_polarity;
	} vsp_status_a_t;

	// Live status of slicer B
	typedef struct packed {
		logic hlock;
		logic vsync_stable;
		logic field_parity;
	} vsp_status_b_t;

	// Field status word layout
	typedef struct packed {
		logic [4:0] rsvd;
		logic       hlock_a;
		logic       vsync_stable_a;
		logic       field_parity_a;
		logic       hf_damping_field_flag;
		logic [1:0] noise;
		logic       group_delay_seen;
		logic       group_delay_polarity;
		logic       hlock_b;
		logic       vsync_stable_b;
		logic       field_parity_b;
	} vsp_field_status_t;

	// Line filter control layout
	typedef struct packed {
		logic       rsvd;
		logic [6:0] data_start_level_a;
		logic       level_accumulator_on;
		logic       clock_pll_track_on;
		logic       lowpass_on;
		logic       prefilter_on;
		logic       force_positive_delay_comp;
		logic       force_negative_delay_comp;
		logic       force_attenuation_comp;
		logic       force_noise_comp;
	} vsp_filt_reg_t;

	// Line service control layout
	typedef struct packed {
		logic         rsvd_hi;
		logic [2:0]   majority_sample_count;
		logic [1:0]   level_average_count;
		logic [2:0]   level_filter_divider;
		vsp_service_t service_standard_select;
		logic [1:0]   framing_code_select;
		logic [1:0]   rsvd_lo;
	} vsp_serv_reg_t;

	// Global acquisition control layout
	typedef struct packed {
		logic [11:0] rsvd;
		logic        auto_noise_comp;
		logic        auto_attenuation_comp;
		logic        auto_delay_comp;
		logic        external_start_level_select;
	} vsp_glob_reg_t;

	// Configuration delivered to slicer A
	typedef struct packed {
		logic [15:0]  data_pll_increment;
		logic [6:0]   start_level;
		logic         use_ext_start;
		logic         accu_on;
		logic         track_on;
		logic         lowpass_on;
		logic         prefilter_on;
		logic         pos_delay_comp;
		logic         neg_delay_comp;
		logic         atten_comp;
		logic         noise_comp;
		vsp_service_t service;
		logic [1:0]   framing_code_select;
	} vsp_line_cfg_t;

endpackage

// ===== test/vsp_video_model.sv
// Video side model: slicer status, field ends, samples and level filter.
// Assumes its tasks are called right after a rising edge of core_clk_i.
module vsp_video_model (
	// Clock
	input  wire logic                  core_clk_i,
	// Slicer status
	output vsp_pkg::vsp_status_a_t     status_a_o,
	output vsp_pkg::vsp_status_b_t     status_b_o,
	output logic                       field_done_a_o,
	output logic                       field_done_b_o,
	output logic                       hf_damping_line_o,
	output logic      [15:0]           widescreen_bits_o,
	output logic      [11:0]           line_period_o,
	// Data path
	output logic                       cri_done_o,
	output logic                       sample_valid_o,
	output logic                       sample_bit_o,
	output logic      [6:0]            level_filter_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import vsp_pkg::*;

	logic lvl_toggle = 1'b0;

	// Quiet inputs at time zero
	initial begin
		status_a_o = '0;
		status_b_o = '0;
		{field_done_a_o, field_done_b_o, hf_damping_line_o, cri_done_o} = 4'h0;
		widescreen_bits_o = 16'h0000;
		line_period_o = 12'h000;
		{sample_valid_o, sample_bit_o} = 2'h0;
		level_filter_o = 7'h00;
	end

	// Level swings between two values every cycle when enabled
	always @(posedge core_clk_i) begin
		if (lvl_toggle)
			level_filter_o <= level_filter_o ^ 7'h40;
	end

	// One field: optional damping held through the end-of-field pulse on A or B
	task automatic end_field(input logic sel, input vsp_status_a_t a, input vsp_status_b_t b,
		input logic [15:0] w, input logic [11:0] p, input logic damp);
		status_a_o <= a;
		status_b_o <= b;
		widescreen_bits_o <= w;
		line_period_o <= p;
		hf_damping_line_o <= damp;
		@(posedge core_clk_i);
		field_done_a_o <= !sel;
		field_done_b_o <= sel;
		@(posedge core_clk_i);
		field_done_a_o <= 1'b0;
		field_done_b_o <= 1'b0;
		hf_damping_line_o <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// Live status change without a field end
	task automatic set_a(input vsp_status_a_t a);
		status_a_o <= a;
		@(posedge core_clk_i);
	endtask

	// Clock run-in finished level
	task automatic set_cri(input logic c);
		cri_done_o <= c;
		@(posedge core_clk_i);
	endtask

	// One sample; the bit line shows the inverse once released
	task automatic put_sample(input logic b);
		sample_valid_o <= 1'b1;
		sample_bit_o <= b;
		@(posedge core_clk_i);
		sample_valid_o <= 1'b0;
		sample_bit_o <= !b;
		@(posedge core_clk_i);
	endtask

	// Level filter value, optionally swinging
	task automatic set_level(input logic [6:0] v, input logic tog);
		level_filter_o <= v;
		lvl_toggle <= tog;
		@(posedge core_clk_i);
	endtask
endmodule

// ===== test/test_vsp_slicer_params.sv
// Bench for the slicer parameter block: registers, field status, line config.
// Assumes the video model drives every slicer-side input.
module test_vsp_slicer_params;
	timeunit 1ns;
	timeprecision 1ps;
	import vsp_pkg::*;

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

	// Bench driven nets
	logic          clk   = 1'b0;
	logic          rst_n = 1'b0;
	logic [3:0]    addr  = 4'h0;
	logic [15:0]   wdata = 16'h0000;
	logic          wen   = 1'b0;
	logic          ren   = 1'b0;
	int            failures = 0;
	int            total_checks = 0;
	// Model and design nets
	vsp_status_a_t st_a;
	vsp_status_b_t st_b;
	vsp_line_cfg_t cfg;
	logic [15:0]   rd_data;
	logic [15:0]   wide;
	logic [11:0]   period;
	logic [6:0]    lvl;
	logic [6:0]    slc;
	logic          done_a, done_b, damp, cri, s_valid, s_bit, freeze, tick, maj;
	logic [3:0]    comp;

	// Compensation enables as one nibble
	assign comp = {cfg.pos_delay_comp, cfg.neg_delay_comp, cfg.atten_comp, cfg.noise_comp};

	// Clock
	initial forever #12.5 clk = ~clk;

	vsp_slicer_params u_vsp_slicer_params (
		.core_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wdata),
		.wr_en_i(wen), .rd_en_i(ren), .rd_data_o(rd_data), .status_a_i(st_a),
		.status_b_i(st_b), .field_done_a_i(done_a), .field_done_b_i(done_b),
		.hf_damping_line_i(damp), .slicer_b_widescreen_bits_i(wide),
		.line_period_value_i(period), .cri_done_i(cri), .sample_valid_i(s_valid),
		.sample_bit_i(s_bit), .level_filter_i(lvl), .line_cfg_o(cfg),
		.pll_freeze_o(freeze), .filter_tick_o(tick), .majority_bit_o(maj),
		.slicing_level_o(slc));

	vsp_video_model u_vsp_video_model (
		.core_clk_i(clk), .status_a_o(st_a), .status_b_o(st_b), .field_done_a_o(done_a),
		.field_done_b_o(done_b), .hf_damping_line_o(damp), .widescreen_bits_o(wide),
		.line_period_o(period), .cri_done_o(cri), .sample_valid_o(s_valid),
		.sample_bit_o(s_bit), .level_filter_o(lvl));

	// Bus write; leaves a quiet cycle so strobes never clash
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wen <= 1'b1;
		@(posedge clk);
		wen <= 1'b0;
		@(posedge clk);
	endtask

	// Bus read and compare of the one-cycle answer
	task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
		addr <= a;
		ren <= 1'b1;
		@(posedge clk);
		ren <= 1'b0;
		@(negedge clk);
		`CHK(rd_data, e)
		@(posedge clk);
	endtask

	// Config reaches slicer A two edges after the write
	task automatic settle;
		repeat (2) @(posedge clk);
	endtask

	task automatic note(input string s);
		$display("test %s done", s);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim;
	end

	// Main sequence
	initial begin
		int i;
		logic [15:0] v;
		logic [7:0] cnt;
		vsp_status_a_t a;
		vsp_status_b_t b;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 8; i++) chk_rd(4'(i), 16'h0000);
		chk_rd(4'hF, 16'h0000);
		wr(REG_PLL, 16'hFFFF);
		chk_rd(REG_PLL, 16'hFFFF);
		wr(REG_FILT, 16'hFFFF);
		chk_rd(REG_FILT, 16'h7FFF);
		wr(REG_SERV, 16'hFFFF);
		chk_rd(REG_SERV, 16'h7FFC);
		wr(REG_GLOB, 16'hFFFF);
		chk_rd(REG_GLOB, 16'h000F);
		wr(REG_STATUS, 16'hFFFF);
		wr(4'h9, 16'hFFFF);
		chk_rd(REG_STATUS, 16'h0000);
		chk_rd(4'h9, 16'h0000);
		note("registers");
		// Back-to-back fields: damping flag set, then cleared
		u_vsp_video_model.end_field(1'b0, vsp_status_a_t'(7'h7F), vsp_status_b_t'(3'h7),
			16'h0000, 12'h000, 1'b1);
		u_vsp_video_model.end_field(1'b1, vsp_status_a_t'(7'h7F), vsp_status_b_t'(3'h7),
			16'h0000, 12'h000, 1'b0);
		chk_rd(REG_STATUS, 16'h077F);
		// Field snapshots through either slicer, every noise code
		for (i = 0; i < 4; i++) begin
			a = vsp_status_a_t'({3'(i + 5), 2'(i), 2'(3 - i)});
			b = vsp_status_b_t'(3'(i + 3));
			u_vsp_video_model.end_field(i[1], a, b, 16'hA5C3 ^ 16'(i), 12'hABC - 12'(i), i[0]);
			chk_rd(REG_PERIOD, {4'h0, 12'hABC - 12'(i)});
			chk_rd(REG_STATUS, {5'h00, a[6:4], i[0], a[3:0], b});
			chk_rd(REG_WIDE, 16'hA5C3 ^ 16'(i));
		end
		note("field status");
		wr(REG_PLL, 16'hD51F);
		settle;
		`CHK(cfg.data_pll_increment, 16'hD51F)
		// Filter bits, forced compensation and start level source
		for (i = 0; i < 2; i++) begin
			v = (i == 0) ? 16'h55A5 : 16'h2A5A;
			wr(REG_GLOB, (i == 0) ? 16'h0001 : 16'h0000);
			wr(REG_FILT, v);
			settle;
			`CHK(cfg.start_level, v[14:8])
			`CHK(cfg.use_ext_start, 1'(i == 0))
			`CHK({cfg.accu_on, cfg.track_on, cfg.lowpass_on, cfg.prefilter_on}, v[7:4])
			`CHK(comp, v[3:0])
		end
		// Automatic compensation from measurement
		wr(REG_FILT, 16'h0000);
		for (i = 0; i < 3; i++) begin
			wr(REG_GLOB, (i == 2) ? 16'h0000 : 16'h000E);
			u_vsp_video_model.set_a((i == 0) ? 7'h06 : 7'h03);
			settle;
			`CHK(comp, (i == 0) ? 4'hB : ((i == 1) ? 4'h6 : 4'h0))
		end
		note("line filter");
		// Service standards and framing code choices
		for (i = 0; i < 8; i++) begin
			wr(REG_SERV, 16'((i << 4) | ((i % 3) << 2)));
			settle;
			`CHK(3'(cfg.service), 3'(i))
			`CHK(cfg.framing_code_select, 2'(i % 3))
		end
		// One filter tick per divider+1 cycles
		for (i = 0; i < 8; i++) begin
			wr(REG_SERV, 16'(i << 7));
			settle;
			cnt = 8'h00;
			repeat (8 * (i + 1)) begin
				@(negedge clk);
				cnt = cnt + 8'(tick);
			end
			@(posedge clk);
			`CHK(cnt, 8'h08)
		end
		note("line service");
		// Clock PLL freeze after run-in unless tracking
		for (i = 0; i < 3; i++) begin
			wr(REG_FILT, (i == 2) ? 16'h0040 : 16'h0000);
			settle;
			u_vsp_video_model.set_cri(i != 1);
			@(negedge clk);
			`CHK(freeze, 1'(i == 0))
			@(posedge clk);
		end
		// Fifteen-sample majority at its boundary
		wr(REG_SERV, 16'h7000);
		settle;
		for (i = 0; i < 15; i++) u_vsp_video_model.put_sample(i < 8);
		`CHK(maj, 1'b1)
		u_vsp_video_model.put_sample(1'b0);
		`CHK(maj, 1'b0)
		// Single-sample majority passes each bit straight through
		wr(REG_SERV, 16'h0000);
		u_vsp_video_model.put_sample(1'b1);
		`CHK(maj, 1'b1)
		u_vsp_video_model.put_sample(1'b0);
		`CHK(maj, 1'b0)
		// Slicing level pass-through, then averaged swing
		wr(REG_FILT, 16'h0000);
		u_vsp_video_model.set_level(7'h2A, 1'b0);
		settle;
		`CHK(slc, 7'h2A)
		wr(REG_FILT, 16'h0080);
		u_vsp_video_model.set_level(7'h20, 1'b1);
		for (i = 0; i < 4; i++) begin
			wr(REG_SERV, 16'(i << 10));
			repeat (80) @(posedge clk);
			`CHK(slc, 7'h40)
		end
		note("data path");
		end_sim;
	end
endmodule
